/* design/ett_pkg.sv */
// Package: register map, field layout and timing constants for the trigger timer
package ett_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COMPARE = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SRC_W = 2;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int CTRL_EDGE_W = 2;
  localparam int CTRL_STOP_BIT = 6;
  localparam int CTRL_ACAP_BIT = 7;
  localparam int CTRL_LOWSPD_BIT = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  // ----------------------------------------
  // Start edge encodings
  // ----------------------------------------
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HF_PERIOD_NS = 10;
  localparam int NOISE_REJECT_PERIODS = 4;
  localparam int NOISE_REJECT_CYCLES =
    (NOISE_REJECT_PERIODS * HF_PERIOD_NS) / CLK_PERIOD_NS;
  localparam logic [15:0] SRC_DIV_0 = 16'h0080;
  localparam logic [15:0] SRC_DIV_1 = 16'h0010;
  localparam logic [15:0] SRC_DIV_2 = 16'h0004;
  localparam logic [15:0] SRC_DIV_3 = 16'h0001;
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT} ett_state_type;
endpackage

/* design/ett_timer.sv */
// External trigger timer: pin filter, start/stop logic, counter, capture, registers

// Function
// R1 - Auto-capture copies counter on source clock
// R2 - Software waits one source period before reading
// R3 - Counter holds until trigger, then counts
// R4 - Start edge field picks rise or fall
// R5 - Stop option set: match clears, halts, interrupts
// R6 - Stop option set: opposite edge aborts silently
// R7 - Halted counter restarts from zero on trigger
// R8 - Stop option clear: match clears, halts, interrupts
// R9 - Stop option clear: opposite edge ignored
// R10 - Stop option clear: early trigger ignored
// R11 - Filter rejects pulses of four clocks or less
// R12 - Source holds pin twelve clocks minimum
// R13 - Filter bypassed in low-speed modes
// R14 - Low-speed: source holds one machine cycle
// R15 - Trigger pin synchronised before edge detection
// R16 - Software configures before arming start edge
module ett_timer
  import ett_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Trigger pin
  input wire logic triggerPin,
  // Match interrupt request
  output logic matchInterrupt
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CNT_W-1:0] compare_ff;
  logic [CNT_W-1:0] capture_ff;
  logic [CNT_W-1:0] count_ff;
  logic [15:0] div_ff;
  logic [2:0] sync_ff;
  logic pinLevel_ff;
  logic [3:0] filt_ff;
  logic prevLevel_ff;
  logic matchSticky_ff;
  logic matchInterrupt_ff;
  logic [31:0] regRdData_ff;
  ett_state_type state_ff;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire logic [1:0] srcSel = ctrl_ff[CTRL_SRC_LSB +: CTRL_SRC_W];
  wire logic [1:0] edgeSel = ctrl_ff[CTRL_EDGE_LSB +: CTRL_EDGE_W];
  wire logic stopOpp = ctrl_ff[CTRL_STOP_BIT];
  wire logic autoCap = ctrl_ff[CTRL_ACAP_BIT];
  wire logic lowSpeed = ctrl_ff[CTRL_LOWSPD_BIT];
  wire logic armed = (edgeSel == EDGE_RISE) || (edgeSel == EDGE_FALL);

  // ----------------------------------------
  // Source clock enable from divider
  // ----------------------------------------
  function automatic logic [15:0] divOf(input logic [1:0] sel);
    logic [15:0] d;
    d = SRC_DIV_3;
    if (sel == 2'h0) d = SRC_DIV_0;
    else if (sel == 2'h1) d = SRC_DIV_1;
    else if (sel == 2'h2) d = SRC_DIV_2;
    return d;
  endfunction
  wire logic [15:0] divLimit = divOf(srcSel) - 16'h0001;
  // Tick on the last count, so a divide of one ticks every clock
  wire logic srcTick = (div_ff >= divLimit);
  wire logic [15:0] nxt_div = srcTick ? 16'h0000 : div_ff + 16'h0001;

  // ----------------------------------------
  // Pin synchroniser and noise filter
  // ----------------------------------------
  // Stage 0 feeds only stage 1; stages 1 and 2 must agree
  wire logic syncAgree = (sync_ff[1] == sync_ff[2]); // R15
  wire logic syncDiffers = syncAgree && (sync_ff[2] != pinLevel_ff);
  // Level must survive past the reject window before it is believed
  wire logic filtDone = (filt_ff > 4'(NOISE_REJECT_CYCLES)); // R11
  wire logic takeLevel = syncDiffers && (lowSpeed || filtDone); // R13
  wire logic [3:0] nxt_filt = !syncDiffers ? 4'h0 :
                              filtDone ? filt_ff : filt_ff + 4'h1;
  wire logic nxt_pinLevel = takeLevel ? sync_ff[2] : pinLevel_ff;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  wire logic rise = pinLevel_ff && !prevLevel_ff;
  wire logic fall = !pinLevel_ff && prevLevel_ff;
  // Same decode serves both the starting and the aborting edge
  function automatic logic pickEdge(input logic [1:0] sel, input logic up, input logic down);
    logic e;
    e = down;
    if (sel == EDGE_RISE) e = up;
    return e;
  endfunction
  wire logic trigEdge = pickEdge(edgeSel, rise, fall); // R4
  wire logic oppEdge = pickEdge(edgeSel, fall, rise);

  // ----------------------------------------
  // Counter and state
  // ----------------------------------------
  wire logic counting = (state_ff == ST_COUNT);
  // Checked one count ahead, so the counter never shows a nonzero compare value
  wire logic match = counting && srcTick && (count_ff + 1'b1 == compare_ff);
  wire logic abort = counting && stopOpp && oppEdge && !match; // R6 R9
  wire logic start = armed && !counting && trigEdge; // R3 R10
  ett_state_type nxt_state;
  logic [CNT_W-1:0] nxt_count;
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_COUNT; // R7
          nxt_count = '0;
        end
      end
      ST_COUNT: begin
        if (match || abort) begin
          nxt_state = ST_IDLE; // R5 R8
          nxt_count = '0;
        end else if (srcTick) begin
          nxt_count = count_ff + 1'b1; // R3
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_count = '0;
      end
    endcase
    // Disarming overrides everything and parks the counter at zero
    if (!armed) begin
      nxt_state = ST_IDLE;
      nxt_count = '0;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // One address compare shared by the strobes and the read mux
  function automatic logic isAddr(input logic [3:0] addr, input logic [3:0] target);
    return addr == target;
  endfunction
  wire logic wrCtrl = regWrite && isAddr(regAddr, ADDR_CTRL);
  wire logic wrCmp = regWrite && isAddr(regAddr, ADDR_COMPARE);
  wire logic rdStatus = regRead && isAddr(regAddr, ADDR_STATUS);
  // Capture follows the source clock, so the first value lags enable by a tick
  wire logic [CNT_W-1:0] nxt_capture = (autoCap && srcTick) ? count_ff : capture_ff; // R1
  // Hardware set wins over read-clear
  wire logic nxt_sticky = match || (matchSticky_ff && !rdStatus);
  wire logic [31:0] statusWord = {30'h0, counting, matchSticky_ff};
  // Unmapped offsets and idle cycles read as zero
  logic [31:0] nxt_rd;
  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (isAddr(regAddr, ADDR_CTRL)) nxt_rd = 32'(ctrl_ff);
    else if (isAddr(regAddr, ADDR_COMPARE)) nxt_rd = 32'(compare_ff);
    else if (isAddr(regAddr, ADDR_CAPTURE)) nxt_rd = 32'(capture_ff);
    else if (isAddr(regAddr, ADDR_STATUS)) nxt_rd = statusWord;
    if (!regRead) nxt_rd = 32'h0000_0000;
  end

  // ----------------------------------------
  // Control and compare registers
  // ----------------------------------------
  // Capture and status have no write path: they are read-only
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_ff <= regWrData[CTRL_W-1:0];
    end
  end

  // Reset compare is all ones, one tick short of the longest count, which a compare of zero gives by wrapping
  always_ff @(posedge clock) begin
    if (reset) begin
      compare_ff <= CNT_W'(COMPARE_RESET);
    end else if (wrCmp) begin
      compare_ff <= regWrData[CNT_W-1:0];
    end
  end

  // ----------------------------------------
  // Source clock divider
  // ----------------------------------------
  // Free-running, so arming never waits on a divider restart
  always_ff @(posedge clock) begin
    if (reset) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // ----------------------------------------
  // Pin synchroniser, filter and edge history
  // ----------------------------------------
  // The pin enters here and nowhere else
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], triggerPin}; // R15
    end
  end

  // Count clears whenever the synchronised level stops disagreeing
  always_ff @(posedge clock) begin
    if (reset) begin
      filt_ff <= 4'h0;
    end else begin
      filt_ff <= nxt_filt; // R11
    end
  end

  // Both levels reset alike, so reset itself makes no edge
  always_ff @(posedge clock) begin
    if (reset) begin
      pinLevel_ff <= 1'b0;
    end else begin
      pinLevel_ff <= nxt_pinLevel;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prevLevel_ff <= 1'b0;
    end else begin
      prevLevel_ff <= pinLevel_ff;
    end
  end

  // ----------------------------------------
  // Counter, state and capture
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      capture_ff <= '0;
    end else begin
      capture_ff <= nxt_capture; // R1
    end
  end

  // ----------------------------------------
  // Match flag, interrupt and read data
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      matchSticky_ff <= 1'b0;
    end else begin
      matchSticky_ff <= nxt_sticky;
    end
  end

  // One-cycle pulse, a clock after the match tick
  always_ff @(posedge clock) begin
    if (reset) begin
      matchInterrupt_ff <= 1'b0;
    end else begin
      matchInterrupt_ff <= match; // R5 R8
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      regRdData_ff <= 32'h0000_0000;
    end else begin
      regRdData_ff <= nxt_rd;
    end
  end

  assign regRdData = regRdData_ff;
  assign matchInterrupt = matchInterrupt_ff;
endmodule

/* verification/ett_timer_checker.sv */
// Checker: port-level properties of the trigger timer
module ett_checker
  import ett_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port and pins
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic triggerPin,
  input wire logic matchInterrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic armedSeen_ff;
  always_ff @(posedge clock) begin
    armedSeen_ff <= !reset && (armedSeen_ff || (regWrite && regAddr == ADDR_CTRL));
  end
  sequence s_rd(a);
    regRead && regAddr == a;
  endsequence
  sequence s_wr(a);
    regWrite && regAddr == a;
  endsequence
  property p_pulse;
    matchInterrupt |=> !matchInterrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt longer than one cycle");
  property p_idle;
    !regRead |=> regRdData == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_unmapped;
    regRead && regAddr[1:0] != 2'h0 |=> regRdData == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl;
    s_rd(ADDR_CTRL) |=> regRdData[31:9] == 23'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control upper bits set");
  property p_cap;
    s_rd(ADDR_CAPTURE) |=> regRdData[31:16] == 16'h0;
  endproperty
  a_cap: assert property (p_cap) else $error("capture upper bits set");
  property p_status;
    s_rd(ADDR_STATUS) |=> regRdData[31:2] == 30'h0;
  endproperty
  a_status: assert property (p_status) else $error("status upper bits set");
  property p_back;
    s_wr(ADDR_COMPARE) ##1 s_rd(ADDR_COMPARE) |=> regRdData[15:0] == $past(regWrData[15:0], 2);
  endproperty
  a_back: assert property (p_back) else $error("compare readback wrong");
  // No control write since reset, so no match interrupt may fire
  property p_quiet;
    !armedSeen_ff |-> !matchInterrupt;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while disarmed");
endmodule
bind ett_timer ett_checker chk (.clock(clock), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .triggerPin(triggerPin), .matchInterrupt(matchInterrupt));

/* verification/ett_pulse_source.sv */
// Partner: external pulse source on the trigger pin
module ett_pulse_source (
  // Clock
  input wire logic clock,
  // Trigger pin
  output logic triggerPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial triggerPin = 1'b0;
  // Callers hold 12 clocks or more unless probing the filter
  task automatic drive(input logic level, input int cycles);
    @(posedge clock) triggerPin <= level;
    repeat (cycles) @(posedge clock);
  endtask
endmodule

/* verification/test_ett_timer.sv */
// Testbench: directed scenarios for the trigger timer
module test_ett_timer;
  import ett_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, regWrite, regRead, triggerPin, matchInterrupt;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, rdVal;
  int failures = 0;
  int compares = 0;
  ett_timer dut (.clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .triggerPin(triggerPin), .matchInterrupt(matchInterrupt));
  ett_pulse_source src (.clock(clock), .triggerPin(triggerPin));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Bus tasks, entered just after a rising edge
  // ----
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock) regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock) regRead <= 1'b0;
    @(negedge clock) rdVal = regRdData;
    @(posedge clock);
  endtask
  task automatic arm(input logic [31:0] cmp, input logic [31:0] ctrl);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_COMPARE, cmp);
    wr(ADDR_CTRL, ctrl);
  endtask
  task automatic irq(input int n, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (n) @(negedge clock) hit = hit | matchInterrupt;
    @(posedge clock);
    check(hit, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic regs;
    rd(ADDR_CTRL);
    check(rdVal, 32'h0);
    rd(ADDR_COMPARE);
    check(rdVal, 32'hFFFF);
    wr(ADDR_CAPTURE, 32'h1234);
    rd(ADDR_CAPTURE);
    check(rdVal, 32'h0);
    rd(4'h2);
    check(rdVal, 32'h0);
    regAddr <= ADDR_COMPARE;
    regWrData <= 32'h00AB;
    regWrite <= 1'b1;
    @(posedge clock) regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clock) regRead <= 1'b0;
    @(negedge clock) check(regRdData, 32'h00AB);
    @(posedge clock);
  endtask
  task automatic stopClear;
    arm(32'h0040, 32'h0023);
    src.drive(1'b1, 20);
    src.drive(1'b0, 20);
    src.drive(1'b1, 20);
    irq(30, 1'b1);
    rd(ADDR_STATUS);
    check(rdVal[0], 1'b1);
  endtask
  task automatic stopSet;
    src.drive(1'b1, 20);
    arm(32'h0200, 32'h0073);
    src.drive(1'b0, 20);
    rd(ADDR_STATUS);
    check(rdVal[1], 1'b1);
    src.drive(1'b1, 20);
    irq(600, 1'b0);
    rd(ADDR_STATUS);
    check(rdVal[1:0], 2'h0);
    src.drive(1'b0, 0);
    irq(500, 1'b0);
    irq(100, 1'b1);
    src.drive(1'b1, 20);
  endtask
  task automatic filt(input logic [31:0] low, input logic exp);
    src.drive(1'b0, 20);
    arm(32'h0003, low | 32'h0023);
    src.drive(1'b1, 3);
    src.drive(1'b0, 0);
    irq(60, exp);
  endtask
  task automatic capture;
    arm(32'h0200, 32'h00A3);
    src.drive(1'b1, 40);
    rd(ADDR_CAPTURE);
    check(rdVal != 0 && rdVal < 32'h0200, 1'b1);
    wr(ADDR_CTRL, 32'h0);
  endtask
  initial begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    regs();
    stopClear();
    stopSet();
    filt(32'h0, 1'b0);
    filt(32'h0100, 1'b1);
    capture();
    report_and_stop();
  end
endmodule
